// ### hw/mult_pkg.sv
package mult_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_PROD_LO = 4'h4;
	localparam logic [3:0] OFS_PROD_HI = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTRL_DUAL = 0;
	localparam int CTRL_DATA_REG = 1;
	localparam int CTRL_SIGN_REG = 2;
	localparam int CTRL_OUT_LO = 3;
	localparam int CTRL_OUT_HI = 4;
	localparam int CTRL_W = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [0:0]
	{
		MODE_WIDE = 1'b0,
		MODE_DUAL = 1'b1
	} mult_mode_e;

endpackage

// ### hw/mult_lane.sv
`timescale 1ns/1ps
// Full precision W x W multiplier, each operand signed or unsigned
module mult_lane #(
	parameter int W = 9
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic a_signed,
	input wire logic b_signed,
	output logic [2*W-1:0] p
);
	wire logic signed [W:0] a_ext;
	wire logic signed [W:0] b_ext;
	wire logic signed [2*W+1:0] p_full;

	// Extend with sign bit or zero, then multiply signed
	assign a_ext = {a_signed & a[W-1], a};
	assign b_ext = {b_signed & b[W-1], b};
	assign p_full = a_ext * b_ext;
	// Low 2W bits hold every result exactly
	assign p = p_full[2*W-1:0];
endmodule

// ### hw/mult_block.sv
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module mult_block
	import mult_pkg::*;
#(
	parameter int AW = 18,
	parameter int NW = 9
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mult_aclr,
	input wire logic mult_clk_en,
	input wire logic [AW-1:0] opnd_a,
	input wire logic [AW-1:0] opnd_b,
	input wire logic operand_a_sign_select,
	input wire logic operand_b_sign_select,
	output logic [2*AW-1:0] product,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	localparam int PW = 2 * AW;

	// ----------------------------------------------------------------
	// Control register and bus slave
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_ff;
	logic [31:0] avs_readdata_ff;
	logic avs_waitrequest_ff;
	wire logic bus_req;
	wire logic bus_done;
	wire logic ctrl_we;
	wire logic [31:0] rd_mux;
	wire logic [31:0] status_word;
	wire logic [CTRL_W-1:0] nxt_ctrl_ff;
	wire logic nxt_avs_waitrequest_ff;
	wire logic [31:0] nxt_avs_readdata_ff;
	wire mult_mode_e mode;
	wire logic sign_a_eff;
	wire logic sign_b_eff;
	wire logic [PW-1:0] raw_prod;

	assign bus_req = avs_read | avs_write;
	assign bus_done = bus_req & ~avs_waitrequest_ff;
	assign ctrl_we = avs_write & bus_done & (avs_address == OFS_CTRL);
	assign nxt_ctrl_ff = ctrl_we ? avs_writedata[CTRL_W-1:0] : ctrl_ff;
	assign nxt_avs_waitrequest_ff = ~(bus_req & avs_waitrequest_ff);
	assign status_word = {29'h0, sign_b_eff, sign_a_eff, mode};
	assign rd_mux = (avs_address == OFS_CTRL) ?
		{{(32-CTRL_W){1'b0}}, ctrl_ff} :
		(avs_address == OFS_PROD_LO) ? product[31:0] :
		(avs_address == OFS_PROD_HI) ? {{(64-PW){1'b0}}, product[PW-1:32]} :
		(avs_address == OFS_STATUS) ? status_word : RDATA_RST;
	assign nxt_avs_readdata_ff = (avs_read & avs_waitrequest_ff) ?
		rd_mux : avs_readdata_ff;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ctrl_ff <= CTRL_RST;
			avs_waitrequest_ff <= 1'b1;
			avs_readdata_ff <= RDATA_RST;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl_ff;
			avs_waitrequest_ff <= nxt_avs_waitrequest_ff;
			avs_readdata_ff <= nxt_avs_readdata_ff;
		end
	end

	assign avs_waitrequest = avs_waitrequest_ff;
	assign avs_readdata = avs_readdata_ff;
	assign mode = mult_mode_e'(ctrl_ff[CTRL_DUAL]);

	// ----------------------------------------------------------------
	// Input registers: data and dedicated sign register
	// ----------------------------------------------------------------
	logic [AW-1:0] a_reg_ff;
	logic [AW-1:0] b_reg_ff;
	logic sign_a_ff;
	logic sign_b_ff;
	wire logic [AW-1:0] a_eff;
	wire logic [AW-1:0] b_eff;

	// Shared clock, enable and clear for every multiplier register
	always_ff @(posedge sys_clk or posedge mult_aclr)
	begin
		if (mult_aclr)
		begin
			a_reg_ff <= '0;
			b_reg_ff <= '0;
			sign_a_ff <= 1'b0;
			sign_b_ff <= 1'b0;
		end
		else if (!rst_n)
		begin
			a_reg_ff <= '0;
			b_reg_ff <= '0;
			sign_a_ff <= 1'b0;
			sign_b_ff <= 1'b0;
		end
		else if (mult_clk_en)
		begin
			a_reg_ff <= opnd_a;
			b_reg_ff <= opnd_b;
			sign_a_ff <= operand_a_sign_select;
			sign_b_ff <= operand_b_sign_select;
		end
	end

	assign a_eff = ctrl_ff[CTRL_DATA_REG] ? a_reg_ff : opnd_a;
	assign b_eff = ctrl_ff[CTRL_DATA_REG] ? b_reg_ff : opnd_b;
	// Sign selects taken live or through their own register
	assign sign_a_eff = ctrl_ff[CTRL_SIGN_REG] ?
		sign_a_ff : operand_a_sign_select;
	assign sign_b_eff = ctrl_ff[CTRL_SIGN_REG] ?
		sign_b_ff : operand_b_sign_select;

	// ----------------------------------------------------------------
	// Multipliers: one wide, two narrow
	// ----------------------------------------------------------------
	wire logic [PW-1:0] wide_p;
	wire logic [2*NW-1:0] lo_p;
	wire logic [2*NW-1:0] hi_p;

	// One sign pair feeds every lane of the block
	mult_lane #(.W(AW)) u_wide (
		.a(a_eff),
		.b(b_eff),
		.a_signed(sign_a_eff),
		.b_signed(sign_b_eff),
		.p(wide_p)
	);

	mult_lane #(.W(NW)) u_lo (
		.a(a_eff[NW-1:0]),
		.b(b_eff[NW-1:0]),
		.a_signed(sign_a_eff),
		.b_signed(sign_b_eff),
		.p(lo_p)
	);

	mult_lane #(.W(NW)) u_hi (
		.a(a_eff[2*NW-1:NW]),
		.b(b_eff[2*NW-1:NW]),
		.a_signed(sign_a_eff),
		.b_signed(sign_b_eff),
		.p(hi_p)
	);

	assign raw_prod = (mode == MODE_DUAL) ?
		{hi_p, lo_p} : wide_p;

	// ----------------------------------------------------------------
	// Output registers in 18-bit sections
	// ----------------------------------------------------------------
	logic [AW-1:0] out_lo_ff;
	logic [AW-1:0] out_hi_ff;
	wire logic out_lo_on;
	wire logic out_hi_on;

	// Wide mode joins both sections under one enable
	assign out_lo_on = ctrl_ff[CTRL_OUT_LO];
	assign out_hi_on = (mode == MODE_DUAL) ?
		ctrl_ff[CTRL_OUT_HI] : ctrl_ff[CTRL_OUT_LO];

	always_ff @(posedge sys_clk or posedge mult_aclr)
	begin
		if (mult_aclr)
		begin
			out_lo_ff <= '0;
			out_hi_ff <= '0;
		end
		else if (!rst_n)
		begin
			out_lo_ff <= '0;
			out_hi_ff <= '0;
		end
		else if (mult_clk_en)
		begin
			out_lo_ff <= raw_prod[AW-1:0];
			out_hi_ff <= raw_prod[PW-1:AW];
		end
	end

	assign product = {(out_hi_on ? out_hi_ff : raw_prod[PW-1:AW]),
		(out_lo_on ? out_lo_ff : raw_prod[AW-1:0])};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_unsigned_prod: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_WIDE && !sign_a_eff && !sign_b_eff) |->
		raw_prod == {{AW{1'b0}}, a_eff} * {{AW{1'b0}}, b_eff})
		else $error("unsigned wide product wrong");

	a_signed_prod: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_WIDE && sign_a_eff && sign_b_eff) |->
		$signed(raw_prod) == $signed(a_eff) * $signed(b_eff))
		else $error("signed wide product wrong");

	a_wide_mixed: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_WIDE && !sign_a_eff && sign_b_eff) |->
		$signed(raw_prod) == $signed({1'b0, a_eff}) * $signed(b_eff))
		else $error("mixed sign wide product wrong");

	a_dual_unsigned: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_DUAL && !sign_a_eff && !sign_b_eff) |->
		raw_prod[2*NW-1:0] == a_eff[NW-1:0] * b_eff[NW-1:0] &&
		raw_prod[PW-1:2*NW] == a_eff[2*NW-1:NW] * b_eff[2*NW-1:NW])
		else $error("dual lanes not independent");

	a_dual_hi_signs: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_DUAL && !sign_a_eff && sign_b_eff) |->
		$signed(raw_prod[PW-1:2*NW]) ==
		$signed({1'b0, a_eff[2*NW-1:NW]}) * $signed(b_eff[2*NW-1:NW]))
		else $error("dual high lane sign handling wrong");

	a_dual_signs: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_DUAL && sign_a_eff && !sign_b_eff) |->
		$signed(raw_prod[2*NW-1:0]) ==
		$signed(a_eff[NW-1:0]) * $signed({1'b0, b_eff[NW-1:0]}))
		else $error("dual low lane sign handling wrong");

	a_sign_bypass: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		!ctrl_ff[CTRL_SIGN_REG] |->
		sign_a_eff == operand_a_sign_select &&
		sign_b_eff == operand_b_sign_select)
		else $error("live sign selects not followed");

	a_sign_capture: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(ctrl_ff[CTRL_SIGN_REG] && mult_clk_en && !ctrl_we) |=>
		sign_a_eff == $past(operand_a_sign_select) &&
		sign_b_eff == $past(operand_b_sign_select))
		else $error("sign register missed capture");

	a_data_capture: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(ctrl_ff[CTRL_DATA_REG] && mult_clk_en && !ctrl_we) |=>
		a_eff == $past(opnd_a) && b_eff == $past(opnd_b))
		else $error("data register missed capture");

	a_sign_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(ctrl_ff[CTRL_SIGN_REG] && !mult_clk_en && !ctrl_we) |=>
		$stable(sign_a_eff) && $stable(sign_b_eff))
		else $error("sign register moved without enable");

	a_wide_section: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_WIDE && out_lo_on && mult_clk_en && !ctrl_we) |=>
		product == $past(raw_prod))
		else $error("wide output section not registered whole");

	a_dual_sections: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(mode == MODE_DUAL && out_hi_on && mult_clk_en && !ctrl_we) |=>
		product[PW-1:AW] == $past(raw_prod[PW-1:AW]))
		else $error("dual high section not registered");

	a_outreg_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(out_lo_on && !mult_clk_en && !ctrl_we) |=>
		$stable(product[AW-1:0]))
		else $error("output register moved without enable");

	a_hi_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n || mult_aclr)
		(out_hi_on && !mult_clk_en && !ctrl_we) |=>
		$stable(product[PW-1:AW]))
		else $error("high output section moved without enable");

	a_aclr_zero: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		mult_aclr |-> out_lo_ff == '0 && out_hi_ff == '0 &&
		a_reg_ff == '0 && sign_a_ff == 1'b0)
		else $error("clear did not zero registers");

endmodule

// ### bench/fabric_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Fabric side operand source
// ----------------------------------------
module fabric_model (
	input wire logic sys_clk,
	input wire logic [17:0] nxt_a,
	input wire logic [17:0] nxt_b,
	input wire logic nxt_sa,
	input wire logic nxt_sb,
	output logic [17:0] opnd_a_ff,
	output logic [17:0] opnd_b_ff,
	output logic sa_ff,
	output logic sb_ff
);
	always_ff @(posedge sys_clk)
	begin
		opnd_a_ff <= nxt_a;
		opnd_b_ff <= nxt_b;
		sa_ff <= nxt_sa;
		sb_ff <= nxt_sb;
	end
endmodule

// ### bench/test_embedded_multiplier_sign_regs.sv
`timescale 1ns/1ps
module test_embedded_multiplier_sign_regs
	import mult_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n, mult_aclr, mult_clk_en, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [35:0] product, prev;
	logic [17:0] nxt_a, nxt_b, opnd_a, opnd_b;
	logic nxt_sa, nxt_sb, sa, sb;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [4:0] cfg [9] = '{5'h00, 5'h01, 5'h06, 5'h07, 5'h08, 5'h10, 5'h19,
		5'h0E, 5'h1F};

	fabric_model fabric_model_inst (.sys_clk(sys_clk), .nxt_a(nxt_a),
		.nxt_b(nxt_b), .nxt_sa(nxt_sa), .nxt_sb(nxt_sb), .opnd_a_ff(opnd_a),
		.opnd_b_ff(opnd_b), .sa_ff(sa), .sb_ff(sb));
	mult_block mult_block_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.mult_aclr(mult_aclr), .mult_clk_en(mult_clk_en), .opnd_a(opnd_a),
		.opnd_b(opnd_b), .operand_a_sign_select(sa),
		.operand_b_sign_select(sb), .product(product),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// ----------------------------------------
	// Clock and timeout
	// ----------------------------------------
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------
	// Tasks and models
	// ----------------------------------------
	task automatic end_sim();
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_p(input string n, input logic [35:0] e,
		input logic [35:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_r(input string n, input logic [31:0] e);
		num_checks++;
		if (rd !== e)
		begin
			fails++;
			$display("FAIL %s exp %h got %h", n, e, rd);
		end
	endtask
	task automatic chk_n(input string n, input int e, input int g);
		num_checks++;
		if (g != e)
		begin
			fails++;
			$display("FAIL %s exp %0d got %0d", n, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] adr,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= adr;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk_n("bus wait", 2, n);
	endtask
	task automatic apply(input logic [17:0] a, input logic [17:0] b,
		input logic x, input logic y);
		nxt_a <= a;
		nxt_b <= b;
		nxt_sa <= x;
		nxt_sb <= y;
		@(posedge sys_clk);
	endtask
	function automatic longint lane(input logic [17:0] a,
		input logic [17:0] b, input logic x, input logic y, input int w);
		longint m;
		longint u;
		longint v;
		m = 64'h1 << w;
		u = longint'(a);
		v = longint'(b);
		if (x && a[w-1])
			u -= m;
		if (y && b[w-1])
			v -= m;
		return u * v;
	endfunction
	function automatic logic [35:0] exp_prod(input logic [4:0] c,
		input logic [17:0] a, input logic [17:0] b, input logic x,
		input logic y);
		longint p0;
		longint p1;
		if (c[0])
		begin
			p0 = lane({9'h0, a[8:0]}, {9'h0, b[8:0]}, x, y, 9);
			p1 = lane({9'h0, a[17:9]}, {9'h0, b[17:9]}, x, y, 9);
			return {p1[17:0], p0[17:0]};
		end
		p0 = lane(a, b, x, y, 18);
		return p0[35:0];
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [35:0] e;
		logic [17:0] a, b;
		logic x, y;
		int lat;
		void'($urandom(93));
		{rst_n, mult_aclr, avs_read, avs_write, nxt_sa, nxt_sb} = 6'h00;
		mult_clk_en = 1'b1;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		nxt_a = 18'h0;
		nxt_b = 18'h0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0);
		chk_r("ctrl reset", 32'h0);
		bus(1'b1, 4'h2, 32'h1F);
		bus(1'b0, 4'h2, 32'h0);
		chk_r("unmapped", 32'h0);
		bus(1'b1, OFS_PROD_LO, 32'hFFFF_FFFF);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk_r("ctrl kept", 32'h0);
		prev = 36'h0;
		foreach (cfg[i])
		begin
			bus(1'b1, OFS_CTRL, {27'h0, cfg[i]});
			bus(1'b0, OFS_CTRL, 32'h0);
			chk_r("ctrl", {27'h0, cfg[i]});
			lat = int'(cfg[i][1]) + int'(cfg[i][3]);
			for (int j = 0; j < 10; j++)
			begin
				a = 18'($urandom);
				b = 18'($urandom);
				x = 1'($urandom);
				y = 1'($urandom);
				if (j < 2)
				begin
					a = (j == 0) ? 18'h20100 : 18'h3FFFF;
					b = 18'h3FFFF;
					x = (j == 0);
					y = (j == 0);
				end
				e = exp_prod(cfg[i], a, b, x, y);
				apply(a, b, x, y);
				for (int k = 0; k < 3; k++)
				begin
					#1;
					if (j > 0 || k == 2)
						chk_p("product", (k >= lat) ? e : prev, product);
					@(posedge sys_clk);
				end
				bus(1'b0, OFS_PROD_LO, 32'h0);
				chk_r("prod_lo", e[31:0]);
				bus(1'b0, OFS_PROD_HI, 32'h0);
				chk_r("prod_hi", {28'h0, e[35:32]});
				bus(1'b0, OFS_STATUS, 32'h0);
				chk_r("status", {29'h0, y, x, cfg[i][0]});
				prev = e;
			end
		end
		a = 18'($urandom);
		b = 18'($urandom);
		e = exp_prod(5'h1F, a, b, 1'b0, 1'b1);
		mult_clk_en <= 1'b0;
		apply(a, b, 1'b0, 1'b1);
		repeat (3) @(posedge sys_clk);
		mult_clk_en <= 1'b1;
		#1;
		chk_p("hold", prev, product);
		repeat (2) @(posedge sys_clk);
		#1;
		chk_p("enable", e, product);
		@(posedge sys_clk);
		mult_aclr <= 1'b1;
		#1;
		chk_p("clear", 36'h0, product);
		@(posedge sys_clk);
		mult_aclr <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk_p("reload", e, product);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		e = exp_prod(5'h00, a, b, 1'b0, 1'b1);
		chk_p("reset", e, product);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk_r("ctrl cleared", 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk_r("status after reset", 32'h0000_0004);
		end_sim();
	end
endmodule
